// ---- cts_pkg.sv ----
// What this block does
// - latching switch grounded picks table 2
// - latching switch reaches only two tables
// - momentary press advances tables, wraps around
// - overdrive button held 2 s selects
// - knob click at status screen selects
// - every table change updates display indicator
// - low-range-only mode maps ranges to tables
// - switch plus axle mode: tables 1-2/3-4
// - overdrive mode: on 1, off 2, manual 3
// - low range detection switches to table 2, 3 or 4 by low range
// - up to three low ranges, labelled
// - sensor below idle threshold forces failsafe
//
// Purpose: constants for the calibration table selector
// Assumes: 10 MHz system clock, 32-bit classic Wishbone
// Notes:   tables are coded 0..3 for tables 1..4
package cts_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int OD_HOLD_S = 2;
  localparam int DEBOUNCE_MS = 10;
  localparam int OD_HOLD_CYC = CLK_HZ * OD_HOLD_S;
  localparam int DEBOUNCE_CYC = (CLK_HZ / 1000) * DEBOUNCE_MS;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] STATE_OFS = 8'h0C;
  localparam logic [7:0] IDLE_OFS = 8'h10;

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MOMENT_BIT = 2;
  localparam int CTRL_NTAB_LSB = 3;
  localparam int CTRL_LOWDET_BIT = 5;
  localparam int CTRL_MANUAL_BIT = 6;
  localparam int CTRL_ODHOLD_BIT = 7;
  localparam int CTRL_KNOB_BIT = 8;
  localparam int CTRL_W = 9;
  localparam logic [8:0] CTRL_RST = 9'h008;

  // ----------------------------------------------------------------
  // status / mask bits, state and threshold
  // ----------------------------------------------------------------
  localparam int EV_TABLE = 0;
  localparam int EV_FAULT = 1;
  localparam int EV_LOW = 2;
  localparam int EV_W = 3;
  localparam int IDLE_W = 10;
  localparam logic [9:0] IDLE_RST = 10'h048;

  // table selection modes
  typedef enum logic [1:0] {
    CTS_MODE_SWITCH = 2'b00,
    CTS_MODE_AXLE = 2'b01,
    CTS_MODE_SW_AXLE = 2'b10,
    CTS_MODE_OD = 2'b11
  } cts_mode_e;

  // overdrive state input coding
  localparam logic [1:0] OD_ON = 2'b00;
  localparam logic [1:0] OD_OFF = 2'b01;
  localparam logic [1:0] OD_MANUAL = 2'b10;

endpackage

// ---- cts_debounce.sv ----
// Purpose: level debouncer for a mechanical switch input
// Assumes: input already synchronous to clock
// Notes:   output changes only after input stable CYC cycles
`timescale 1ns/1ns
`default_nettype none
module cts_debounce #(
  parameter int CYC = 100_000,
  parameter logic RST_LVL = 1'b1
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // switch
  input wire logic raw,
  output logic stable
);

  localparam int CW = $clog2(CYC + 1);
  localparam logic [CW-1:0] LAST = CW'(CYC - 1);

  logic [CW-1:0] cnt_r, cnt_nxt;
  logic lvl_r, lvl_nxt;

  // count while raw differs; accept after a quiet stretch
  always_comb begin
    cnt_nxt = '0;
    lvl_nxt = lvl_r;
    if (raw != lvl_r) begin
      if (cnt_r == LAST) begin
        lvl_nxt = raw;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cnt_r <= '0;
      lvl_r <= RST_LVL;
    end else begin
      cnt_r <= cnt_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign stable = lvl_r;

endmodule // cts_debounce
`default_nettype wire

// ---- cts_selector.sv ----
// Purpose: picks the active calibration table and flags sensor fault
// Assumes: switch inputs synchronous, grounded inputs active low
// Notes:   registers over classic Wishbone, one wait state per access
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module cts_selector
  import cts_pkg::*;
#(
  parameter int HOLD_CYC = OD_HOLD_CYC,
  parameter int DEB_CYC = DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // driver switches
  input wire logic table_sel_n,
  input wire logic od_button,
  input wire logic knob_click,
  input wire logic status_screen,
  input wire logic [1:0] od_state,
  // transfer case
  input wire logic all_axle_drive,
  input wire logic low_range_n,
  input wire logic [1:0] low_range_idx,
  // throttle sensor sample
  input wire logic [9:0] throttle_angle_sensor,
  // results
  output logic [1:0] active_table,
  output logic [1:0] display_table,
  output logic display_update,
  output logic [1:0] low_range_label,
  output logic sensor_fault,
  output logic failsafe_mode,
  output logic irq
);

  localparam int HW = $clog2(HOLD_CYC + 1);
  localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYC - 1);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // next table in the momentary cycle, wrapping at tables in use
  function automatic logic [1:0] next_tab(input logic [1:0] cur,
                                          input logic [1:0] last);
    next_tab = (cur >= last) ? 2'h0 : cur + 2'h1;
  endfunction

  // byte-lane merge for writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? wd[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  // ----------------------------------------------------------------
  // debounced switches
  // ----------------------------------------------------------------
  logic sel_db_n, od_db, low_db_n;

  cts_debounce #(.CYC(DEB_CYC), .RST_LVL(1'b1)) u_sel_deb (
    .clock(clock), .rst_n(rst_n), .raw(table_sel_n), .stable(sel_db_n)
  );
  cts_debounce #(.CYC(DEB_CYC), .RST_LVL(1'b0)) u_od_deb (
    .clock(clock), .rst_n(rst_n), .raw(od_button), .stable(od_db)
  );
  cts_debounce #(.CYC(DEB_CYC), .RST_LVL(1'b1)) u_low_deb (
    .clock(clock), .rst_n(rst_n), .raw(low_range_n), .stable(low_db_n)
  );

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [EV_W-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  logic [IDLE_W-1:0] idle_r, idle_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rd_r, rd_nxt;

  cts_mode_e mode;
  logic momentary, low_det_en, manual_en, od_hold_en, knob_en;
  logic [1:0] ntab_m1;

  assign mode = cts_mode_e'(ctrl_r[CTRL_MODE_LSB +: 2]);
  assign momentary = ctrl_r[CTRL_MOMENT_BIT];
  assign ntab_m1 = ctrl_r[CTRL_NTAB_LSB +: 2];
  assign low_det_en = ctrl_r[CTRL_LOWDET_BIT];
  assign manual_en = ctrl_r[CTRL_MANUAL_BIT];
  assign od_hold_en = ctrl_r[CTRL_ODHOLD_BIT];
  assign knob_en = ctrl_r[CTRL_KNOB_BIT];

  // ----------------------------------------------------------------
  // selection events
  // ----------------------------------------------------------------
  logic sel_prev_r, sel_prev_nxt;
  logic [HW-1:0] hold_r, hold_nxt;
  logic held_r, held_nxt;
  logic hold_ev, press_ev, knob_ev, adv_ev;

  // held counter saturates so a long hold gives one event only
  always_comb begin
    hold_nxt = hold_r;
    held_nxt = held_r;
    hold_ev = 1'b0;
    sel_prev_nxt = sel_db_n;
    if (!od_db) begin
      hold_nxt = '0;
      held_nxt = 1'b0;
    end else if (!held_r) begin
      if (hold_r == HOLD_LAST) begin
        held_nxt = 1'b1;
        hold_ev = od_hold_en;
      end else begin
        hold_nxt = hold_r + 1'b1;
      end
    end
  end

  assign press_ev = sel_prev_r & ~sel_db_n;
  assign knob_ev = knob_click & status_screen & knob_en;
  assign adv_ev = press_ev | hold_ev | knob_ev;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hold_r <= '0;
      held_r <= 1'b0;
      sel_prev_r <= 1'b1;
    end else begin
      hold_r <= hold_nxt;
      held_r <= held_nxt;
      sel_prev_r <= sel_prev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // table choice
  // ----------------------------------------------------------------
  logic [1:0] cyc_r, cyc_nxt, tab_r, tab_nxt, disp_r, label_r, label_nxt;
  logic upd_r, upd_nxt, fault_r, fault_nxt;
  logic low_eng, low_on, sel_on;
  logic [1:0] low_tab;

  assign low_eng = ~low_db_n;
  assign low_on = low_eng & low_det_en;
  assign low_tab = (low_range_idx > 2'h2) ? 2'h3 : low_range_idx + 2'h1;
  assign sel_on = ~sel_db_n;

  // momentary walk counter, then per-mode mapping
  always_comb begin
    cyc_nxt = cyc_r;
    if (adv_ev) begin
      cyc_nxt = next_tab(cyc_r, ntab_m1);
    end
    tab_nxt = tab_r;
    case (mode)
      CTS_MODE_SWITCH: begin
        if (low_on) begin
          tab_nxt = low_tab;
        end else if (momentary) begin
          tab_nxt = cyc_r;
        end else begin
          tab_nxt = {1'b0, sel_on};
        end
      end
      CTS_MODE_AXLE: begin
        tab_nxt = low_eng ? low_tab : 2'h0;
      end
      CTS_MODE_SW_AXLE: begin
        tab_nxt = {all_axle_drive, sel_on};
      end
      CTS_MODE_OD: begin
        if (od_state == OD_ON) begin
          tab_nxt = 2'h0;
        end else if (od_state == OD_MANUAL && manual_en) begin
          tab_nxt = 2'h2;
        end else begin
          tab_nxt = 2'h1;
        end
      end
      default: tab_nxt = tab_r;
    endcase
    upd_nxt = (tab_nxt != tab_r);
    label_nxt = (low_on || (mode == CTS_MODE_AXLE && low_eng)) ?
                low_tab : 2'h0;
    fault_nxt = (throttle_angle_sensor < idle_r);
  end

  // display copy follows each change, one update pulse per change
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cyc_r <= 2'h0;
      tab_r <= 2'h0;
      disp_r <= 2'h0;
      upd_r <= 1'b0;
      label_r <= 2'h0;
      fault_r <= 1'b0;
    end else begin
      cyc_r <= cyc_nxt;
      tab_r <= tab_nxt;
      disp_r <= tab_r;
      upd_r <= upd_nxt;
      label_r <= label_nxt;
      fault_r <= fault_nxt;
    end
  end

  // ----------------------------------------------------------------
  // wishbone register file and interrupt status
  // ----------------------------------------------------------------
  logic req, wr;
  logic [EV_W-1:0] ev, clr;
  logic [31:0] st_word;

  assign req = wb_cyc_i & wb_stb_i & ~ack_r;
  assign wr = req & wb_we_i;
  assign ev = {low_on & ~label_r[0] & ~label_r[1], fault_nxt & ~fault_r,
               upd_nxt};
  assign st_word = {25'h0, held_r, sel_on, fault_r, label_r, tab_r};

  // hardware set wins over a same-cycle write-one clear
  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    idle_nxt = idle_r;
    clr = '0;
    rd_nxt = rd_r;
    ack_nxt = req;
    if (wr) begin
      if (wb_adr_i == CTRL_OFS) begin
        ctrl_nxt = CTRL_W'(merge(32'(ctrl_r), wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == STAT_OFS) begin
        clr = EV_W'(merge(32'h0, wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == MASK_OFS) begin
        mask_nxt = EV_W'(merge(32'(mask_r), wb_dat_i, wb_sel_i));
      end else if (wb_adr_i == IDLE_OFS) begin
        idle_nxt = IDLE_W'(merge(32'(idle_r), wb_dat_i, wb_sel_i));
      end
    end
    if (req) begin
      if (wb_adr_i == CTRL_OFS) begin
        rd_nxt = 32'(ctrl_r);
      end else if (wb_adr_i == STAT_OFS) begin
        rd_nxt = 32'(stat_r);
      end else if (wb_adr_i == MASK_OFS) begin
        rd_nxt = 32'(mask_r);
      end else if (wb_adr_i == STATE_OFS) begin
        rd_nxt = st_word;
      end else if (wb_adr_i == IDLE_OFS) begin
        rd_nxt = 32'(idle_r);
      end else begin
        rd_nxt = 32'h0000_0000;
      end
    end
    stat_nxt = (stat_r & ~clr) | ev;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_r <= CTRL_RST;
      stat_r <= '0;
      mask_r <= '0;
      idle_r <= IDLE_RST;
      ack_r <= 1'b0;
      rd_r <= 32'h0000_0000;
    end else begin
      ctrl_r <= ctrl_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      idle_r <= idle_nxt;
      ack_r <= ack_nxt;
      rd_r <= rd_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_r;
  assign wb_dat_o = rd_r;
  assign active_table = tab_r;
  assign display_table = disp_r;
  assign display_update = upd_r;
  assign low_range_label = label_r;
  assign sensor_fault = fault_r;
  assign failsafe_mode = fault_r;
  assign irq = |(stat_r & mask_r);

endmodule // cts_selector
`default_nettype wire

// ---- cts_monitor.sv ----
// Purpose: concurrent checks on the table selector ports
// Assumes: idle threshold left at its reset value
// Notes:   fault checks allow for the sample register stage
`timescale 1ns/1ns
`default_nettype none
module cts_monitor
  import cts_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // sensor and results
  input wire logic [9:0] throttle_angle_sensor,
  input wire logic [1:0] active_table,
  input wire logic [1:0] display_table,
  input wire logic display_update,
  input wire logic sensor_fault,
  input wire logic failsafe_mode,
  input wire logic irq
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  // bus: single wait state, one-cycle ack
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o)
    else $error("request not answered in the next cycle");
  // display follows every table change
  update_on_change_a: assert property (
    active_table != $past(active_table) |-> display_update)
    else $error("table changed without display update");
  update_cause_a: assert property (
    display_update |-> active_table != $past(active_table))
    else $error("display update without table change");
  disp_copy_a: assert property (
    display_update |=> display_table == $past(active_table))
    else $error("display shows a stale table");
  // fault tracks the idle threshold, strict less-than
  fault_set_a: assert property (
    (throttle_angle_sensor < IDLE_RST) [*3] |-> sensor_fault)
    else $error("low sensor not flagged");
  fault_clear_a: assert property (
    (throttle_angle_sensor >= IDLE_RST) [*3] |-> !sensor_fault)
    else $error("fault flagged on a good sensor");
  failsafe_tie_a: assert property (
    sensor_fault == failsafe_mode)
    else $error("failsafe out of step with fault");

  // main scenarios seen
  cover property (display_update);
  cover property ($rose(sensor_fault));
  cover property ($rose(irq));
endmodule // cts_monitor

bind cts_selector cts_monitor i_cts_monitor (.clock, .rst_n, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .throttle_angle_sensor, .active_table,
  .display_table, .display_update, .sensor_fault, .failsafe_mode, .irq);
`default_nettype wire

// ---- cts_driver_model.sv ----
// Purpose: driver switches, transfer case and throttle sensor
// Assumes: levels change just after a rising clock edge
// Notes:   knob strobe is one cycle wide, like the real encoder
`timescale 1ns/1ns
`default_nettype none
module cts_driver_model (
  // clock
  input wire logic clock,
  // driver switches
  output logic table_sel_n,
  output logic od_button,
  output logic knob_click,
  output logic status_screen,
  output logic [1:0] od_state,
  // transfer case and sensor
  output logic all_axle_drive,
  output logic low_range_n,
  output logic [1:0] low_range_idx,
  output logic [9:0] throttle_angle_sensor
);
  // switches open, one axle driven, sensor well above idle
  initial begin
    table_sel_n = 1'b1;
    od_button = 1'b0;
    knob_click = 1'b0;
    status_screen = 1'b0;
    od_state = 2'h0;
    all_axle_drive = 1'b0;
    low_range_n = 1'b1;
    low_range_idx = 2'h0;
    throttle_angle_sensor = 10'h200;
  end
  // all levels at once, so no half-set state is seen
  task automatic set_env(input logic s, input logic a, input logic l,
      input logic [1:0] i, input logic [1:0] o, input logic [9:0] t);
    @(posedge clock);
    table_sel_n <= s;
    all_axle_drive <= a;
    low_range_n <= l;
    low_range_idx <= i;
    od_state <= o;
    throttle_angle_sensor <= t;
  endtask
  // select switch grounded or od button held for n cycles
  task automatic press(input logic od, input int n);
    @(posedge clock);
    if (od) od_button <= 1'b1;
    else table_sel_n <= 1'b0;
    repeat (n) @(posedge clock);
    od_button <= 1'b0;
    table_sel_n <= 1'b1;
  endtask
  // one knob strobe, with or without the status screen up
  task automatic click(input logic scr);
    @(posedge clock);
    status_screen <= scr;
    knob_click <= 1'b1;
    @(posedge clock);
    knob_click <= 1'b0;
  endtask
endmodule // cts_driver_model
`default_nettype wire

// ---- tb_top.sv ----
// Purpose: self-checking bench for the table selector
// Assumes: short debounce and hold counts for simulation
// Notes:   switch waits are debounce plus the two-stage pipeline
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import cts_pkg::*;
  localparam int DEB = 4;
  localparam int HOLD = 20;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, table_sel_n, od_button, knob_click, status_screen;
  logic all_axle_drive, low_range_n, display_update, sensor_fault;
  logic failsafe_mode, irq;
  logic [1:0] od_state, low_range_idx, active_table, display_table;
  logic [1:0] low_range_label;
  logic [9:0] throttle_angle_sensor;
  int n_errors = 0;
  int total_checks = 0;

  always #50 clock = ~clock;

  cts_selector #(.HOLD_CYC(HOLD), .DEB_CYC(DEB)) i_cts_selector (
    .clock, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .table_sel_n, .od_button, .knob_click,
    .status_screen, .od_state, .all_axle_drive, .low_range_n,
    .low_range_idx, .throttle_angle_sensor, .active_table, .display_table,
    .display_update, .low_range_label, .sensor_fault, .failsafe_mode, .irq);
  cts_driver_model i_cts_driver_model (.clock, .table_sel_n, .od_button,
    .knob_click, .status_screen, .od_state, .all_axle_drive, .low_range_n,
    .low_range_idx, .throttle_angle_sensor);

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
      input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 8);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      n_errors++;
      conclude();
    end
  endtask
  // debounce, pipeline, then the table and its display copy
  task automatic tab(input logic [1:0] e);
    repeat (DEB + 4) @(posedge clock);
    chk({30'h0, active_table}, {30'h0, e});
    chk({30'h0, display_table}, {30'h0, e});
  endtask
  task automatic env(input logic [31:0] c, input logic s, input logic a,
      input logic l, input logic [1:0] i, input logic [1:0] o,
      input logic [9:0] t, input logic [1:0] e);
    wb(1'b1, CTRL_OFS, c);
    i_cts_driver_model.set_env(s, a, l, i, o, t);
    tab(e);
    chk({30'h0, low_range_label}, {30'h0, l ? 2'h0 : i + 2'h1});
    chk({30'h0, sensor_fault, failsafe_mode},
        {30'h0, {2{t < IDLE_RST}}});
  endtask

  // main sequence: reset, registers, selection inputs, modes
  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h0000_0008);
    wb(1'b0, IDLE_OFS, 32'h0);
    chk(rd, 32'h0000_0048);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    $display("test registers finished");
    wb(1'b1, CTRL_OFS, 32'h0000_001C);
    for (int i = 1; i <= 4; i++) begin
      i_cts_driver_model.press(1'b0, DEB + 2);
      tab(i[1:0]);
    end
    i_cts_driver_model.press(1'b0, DEB - 2);
    tab(2'h0);
    wb(1'b1, CTRL_OFS, 32'h0000_009C);
    i_cts_driver_model.press(1'b1, DEB + HOLD / 2);
    tab(2'h0);
    i_cts_driver_model.press(1'b1, DEB + HOLD + 4);
    tab(2'h1);
    wb(1'b1, CTRL_OFS, 32'h0000_019C);
    i_cts_driver_model.click(1'b0);
    tab(2'h1);
    i_cts_driver_model.click(1'b1);
    tab(2'h2);
    $display("test selection inputs finished");
    chk({31'h0, irq}, 32'h0);
    wb(1'b1, MASK_OFS, 32'h0000_0001);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h1);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd, 32'h0000_0001);
    wb(1'b1, STAT_OFS, 32'h0000_0007);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd, 32'h0000_0000);
    $display("test interrupt finished");
    env(32'h08, 1'b0, 1'b0, 1'b1, 2'h0, 2'h0, 10'h200, 2'h1);
    env(32'h08, 1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 10'h200, 2'h0);
    env(32'h18, 1'b0, 1'b0, 1'b1, 2'h0, 2'h0, 10'h200, 2'h1);
    env(32'h01, 1'b1, 1'b1, 1'b1, 2'h0, 2'h0, 10'h200, 2'h0);
    env(32'h01, 1'b1, 1'b1, 1'b0, 2'h0, 2'h0, 10'h200, 2'h1);
    env(32'h01, 1'b1, 1'b1, 1'b0, 2'h1, 2'h0, 10'h200, 2'h2);
    env(32'h01, 1'b1, 1'b1, 1'b0, 2'h2, 2'h0, 10'h200, 2'h3);
    env(32'h02, 1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 10'h200, 2'h0);
    env(32'h02, 1'b0, 1'b0, 1'b1, 2'h0, 2'h0, 10'h200, 2'h1);
    env(32'h02, 1'b0, 1'b1, 1'b1, 2'h0, 2'h0, 10'h200, 2'h3);
    env(32'h02, 1'b1, 1'b1, 1'b1, 2'h0, 2'h0, 10'h200, 2'h2);
    env(32'h43, 1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 10'h200, 2'h0);
    env(32'h43, 1'b1, 1'b0, 1'b1, 2'h0, 2'h1, 10'h200, 2'h1);
    env(32'h43, 1'b1, 1'b0, 1'b1, 2'h0, 2'h2, 10'h200, 2'h2);
    env(32'h03, 1'b1, 1'b0, 1'b1, 2'h0, 2'h2, 10'h200, 2'h1);
    env(32'h28, 1'b1, 1'b0, 1'b0, 2'h0, 2'h0, 10'h200, 2'h1);
    wb(1'b0, STATE_OFS, 32'h0);
    chk(rd, 32'h0000_0005);
    wb(1'b0, STAT_OFS, 32'h0);
    chk(rd, 32'h0000_0005);
    env(32'h08, 1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 10'h047, 2'h0);
    env(32'h08, 1'b1, 1'b0, 1'b1, 2'h0, 2'h0, 10'h048, 2'h0);
    $display("test modes finished");
    conclude();
  end
endmodule // tb_top
`default_nettype wire
